// >>> src/wdcm_top.sv
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - watchdog disable bit 0 lets timeout force reset; 1 blocks it
// - disable setting written takes effect only at the next system reset
// - special modes start with watchdog reset inhibited; writing 0 enables
// - timeout is bus clock over 2^15 scaled by 1, 4, 16 or 64
// - rate select resets to 0, the shortest period
// - normal mode: rate written once within 64 bus cycles; special: any time
// - write 55 arms, then AA clears the watchdog count
// - other accesses may fall between arm and clear; both before timeout
// - enabled monitor resets when bus clock edges stop for a delay
// - below 10 kHz flagged; 200 kHz or above never flagged
// - watchdog counts only bus clock edges, stops with the clock
// - stop with monitor enabled halts edges and causes monitor reset
// - monitor enable read/write any time, cleared by reset
// - edge select 0 makes interrupt input level, 1 edge only
// - vector by cause and mode: fffe/fffc/fffa, special bffe/bffc/bffa
// - after reset vector fetched in three cycles
// - internal reset drives pin low four cycles, samples two later
module wdcm_top #(
    parameter int ADDR_W      = 8,
    parameter int WD_DIV_LOG2 = wdcm_pkg::WD_DIV_LOG2,
    parameter int CM_CYC      = wdcm_pkg::CM_TIMEOUT_NS / wdcm_pkg::CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // pins
    input  wire logic              bus_clk_pin,
    input  wire logic              stop_pin,
    input  wire logic              special_mode_pin,
    input  wire logic              irq_pin_n,
    input  wire logic              reset_pin_in,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe,
    // to and from processor
    input  wire logic              irq_ack,
    output logic                   irq_request,
    output logic                   sys_reset_n,
    output logic                   vector_fetch,
    output logic [15:0]            reset_vector,
    output logic                   irq
);
    localparam int WD_W = WD_DIV_LOG2 + 7;
    localparam int CM_W = $clog2(CM_CYC + 1);
    // pin level reaches the sequencer through two flip-flops
    localparam int SYNC_DEPTH = 2;

    typedef struct packed {
        logic [2:0]                e_sync;
        logic [1:0]                stop_sync;
        logic [1:0]                mode_sync;
        logic [2:0]                irq_sync;
        logic [1:0]                rp_sync;
        logic                      awready;
        logic                      wready;
        logic                      aw_full;
        logic                      w_full;
        logic [ADDR_W-1:0]         aw_addr;
        logic [7:0]                w_data;
        logic                      w_en;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [1:0]                rresp;
        logic [31:0]               rdata;
        logic [7:0]                setup;
        logic                      rate_written;
        logic [6:0]                win_count;
        logic [7:0]                boot;
        logic                      wd_disabled;
        logic                      reset_inhibit;
        logic                      special;
        logic                      armed;
        logic [WD_W-1:0]           wd_count;
        logic [CM_W-1:0]           cm_count;
        logic [1:0]                status;
        logic [1:0]                mask;
        logic                      irq;
        logic                      irq_request;
        wdcm_pkg::wdcm_rst_type    rst_state;
        logic [1:0]                rst_count;
        wdcm_pkg::wdcm_cause_type  cause;
        logic                      reset_pin_oe;
        logic                      sys_reset_n;
        logic                      vector_fetch;
        logic [15:0]               reset_vector;
    } wdcm_state_type;

    wdcm_state_type  s;
    wdcm_state_type  next_s;
    logic            e_edge;
    logic            do_wr;
    logic            wr_hit;
    logic            rd_hit;
    logic            wd_timeout;
    logic            cm_fail;
    logic            go_int;
    logic [WD_W-1:0] wd_limit;
    logic [7:0]      rd_byte;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s = s;
        // two-stage synchronisers; edge detect reads stages two and three
        next_s.e_sync    = {s.e_sync[1:0], bus_clk_pin};
        next_s.stop_sync = {s.stop_sync[0], stop_pin};
        next_s.mode_sync = {s.mode_sync[0], special_mode_pin};
        next_s.irq_sync  = {s.irq_sync[1:0], irq_pin_n};
        next_s.rp_sync   = {s.rp_sync[0], reset_pin_in};
        e_edge = s.e_sync[1] & ~s.e_sync[2] & ~s.stop_sync[1];

        // write channel, address and data in either order
        if (s.awready && awvalid)
        begin
            next_s.awready = 1'b0;
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (s.wready && wvalid)
        begin
            next_s.wready = 1'b0;
            next_s.w_full = 1'b1;
            next_s.w_data = wdata[7:0];
            next_s.w_en   = wstrb[0];
        end
        do_wr = s.aw_full & s.w_full & ~s.bvalid;
        case (s.aw_addr)
            wdcm_pkg::OFF_SERVICE, wdcm_pkg::OFF_SETUP, wdcm_pkg::OFF_BOOT,
            wdcm_pkg::OFF_TEST, wdcm_pkg::OFF_STATUS, wdcm_pkg::OFF_MASK,
            wdcm_pkg::OFF_CAUSE, wdcm_pkg::OFF_VECTOR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (do_wr)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_hit ? wdcm_pkg::RESP_OKAY : wdcm_pkg::RESP_SLVERR;
        end
        if (s.bvalid && bready)
        begin
            next_s.bvalid  = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready  = 1'b1;
        end

        // read channel
        rd_hit = 1'b1;
        case (araddr)
            wdcm_pkg::OFF_SERVICE: rd_byte = 8'h00;
            wdcm_pkg::OFF_SETUP:   rd_byte = s.setup;
            wdcm_pkg::OFF_BOOT:    rd_byte = s.boot;
            wdcm_pkg::OFF_TEST:    rd_byte = {7'h00, s.reset_inhibit};
            wdcm_pkg::OFF_STATUS:  rd_byte = {6'h00, s.status};
            wdcm_pkg::OFF_MASK:    rd_byte = {6'h00, s.mask};
            wdcm_pkg::OFF_CAUSE:   rd_byte = {5'h00, s.special, s.cause};
            default:
            begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
        if (s.arready && arvalid)
        begin
            next_s.arready = 1'b0;
            next_s.rvalid  = 1'b1;
            next_s.rresp   = (rd_hit || araddr == wdcm_pkg::OFF_VECTOR) ?
                             wdcm_pkg::RESP_OKAY : wdcm_pkg::RESP_SLVERR;
            next_s.rdata   = (araddr == wdcm_pkg::OFF_VECTOR) ?
                             {16'h0000, s.reset_vector} : {24'h000000, rd_byte};
        end
        if (s.rvalid && rready)
        begin
            next_s.rvalid  = 1'b0;
            next_s.arready = 1'b1;
        end

        // watchdog: 2^15 prescale times 1, 4, 16 or 64
        wd_limit = (WD_W'(1) << (WD_DIV_LOG2 + 2 * int'(s.setup[1:0]))) - WD_W'(1);
        wd_timeout = (s.rst_state == wdcm_pkg::RS_RUN) && e_edge && s.wd_count == wd_limit;
        if (s.rst_state == wdcm_pkg::RS_RUN && e_edge)
            next_s.wd_count = wd_timeout ? '0 : s.wd_count + WD_W'(1);
        if (e_edge && s.win_count != 7'(wdcm_pkg::RATE_WINDOW_CYC))
            next_s.win_count = s.win_count + 7'h01;

        // clock monitor: aclk cycles since last bus clock edge
        cm_fail = 1'b0;
        if (s.rst_state != wdcm_pkg::RS_RUN || !s.setup[wdcm_pkg::SETUP_CME] || e_edge)
            next_s.cm_count = '0;
        else if (s.cm_count == CM_W'(CM_CYC - 1))
            cm_fail = 1'b1;
        else
            next_s.cm_count = s.cm_count + CM_W'(1);

        // register writes
        if (do_wr && s.w_en)
        begin
            case (s.aw_addr)
                wdcm_pkg::OFF_SERVICE:
                begin
                    if (s.w_data == wdcm_pkg::SERVICE_ARM)
                        next_s.armed = 1'b1;
                    else
                    begin
                        next_s.armed = 1'b0;
                        if (s.armed && s.w_data == wdcm_pkg::SERVICE_CLEAR)
                            next_s.wd_count = '0;
                    end
                end
                wdcm_pkg::OFF_SETUP:
                begin
                    next_s.setup[7:3] = s.w_data[7:3] & wdcm_pkg::SETUP_WMASK[7:3];
                    if (s.special || (!s.rate_written &&
                        s.win_count != 7'(wdcm_pkg::RATE_WINDOW_CYC)))
                    begin
                        next_s.setup[1:0]   = s.w_data[1:0];
                        next_s.rate_written = 1'b1;
                    end
                end
                wdcm_pkg::OFF_BOOT: next_s.boot = s.w_data;
                wdcm_pkg::OFF_TEST: next_s.reset_inhibit = s.w_data[wdcm_pkg::TEST_INHIB];
                wdcm_pkg::OFF_STATUS: next_s.status = s.status & ~s.w_data[1:0];
                wdcm_pkg::OFF_MASK: next_s.mask = s.w_data[1:0];
                default: next_s.mask = next_s.mask;
            endcase
        end
        // events set after the clear so that set wins
        if (wd_timeout)
            next_s.status[wdcm_pkg::ST_WD] = 1'b1;
        if (cm_fail)
            next_s.status[wdcm_pkg::ST_CM] = 1'b1;
        next_s.irq = |(next_s.status & next_s.mask);

        // external interrupt input, level or falling edge
        if (!s.setup[wdcm_pkg::SETUP_EDGE])
            next_s.irq_request = ~s.irq_sync[1];
        else if (s.irq_sync[2] && !s.irq_sync[1])
            next_s.irq_request = 1'b1;
        else if (irq_ack)
            next_s.irq_request = 1'b0;

        // reset sequencer
        go_int = 1'b0;
        case (s.rst_state)
            wdcm_pkg::RS_RUN:
            begin
                if (!s.rp_sync[1])
                begin
                    go_int       = 1'b1;
                    next_s.cause = wdcm_pkg::CAUSE_PIN;
                end
                else if (cm_fail)
                begin
                    go_int       = 1'b1;
                    next_s.cause = wdcm_pkg::CAUSE_CM;
                end
                else if (wd_timeout && !s.wd_disabled && !s.reset_inhibit)
                begin
                    go_int       = 1'b1;
                    next_s.cause = wdcm_pkg::CAUSE_WD;
                end
            end
            wdcm_pkg::RS_DRIVE:
            begin
                next_s.rst_count = s.rst_count + 2'h1;
                if (s.rst_count == 2'(wdcm_pkg::RST_DRIVE_CYC - 1))
                begin
                    next_s.reset_pin_oe = 1'b0;
                    next_s.rst_state    = wdcm_pkg::RS_WAIT;
                    next_s.rst_count    = 2'h0;
                end
            end
            wdcm_pkg::RS_WAIT:
            begin
                next_s.rst_count = s.rst_count + 2'h1;
                if (s.rst_count == 2'(wdcm_pkg::RST_SAMPLE_CYC + SYNC_DEPTH - 1))
                begin
                    next_s.rst_state     = wdcm_pkg::RS_FETCH;
                    next_s.rst_count     = 2'h0;
                    next_s.sys_reset_n   = 1'b1;
                    next_s.vector_fetch  = 1'b1;
                    next_s.special       = s.mode_sync[1];
                    next_s.reset_inhibit = s.mode_sync[1];
                    if (!s.rp_sync[1])
                        next_s.cause = wdcm_pkg::CAUSE_PIN;
                    case (s.rp_sync[1] ? s.cause : wdcm_pkg::CAUSE_PIN)
                        wdcm_pkg::CAUSE_CM: next_s.reset_vector = s.mode_sync[1] ?
                            wdcm_pkg::VEC_SPC_CM : wdcm_pkg::VEC_CM;
                        wdcm_pkg::CAUSE_WD: next_s.reset_vector = s.mode_sync[1] ?
                            wdcm_pkg::VEC_SPC_WD : wdcm_pkg::VEC_WD;
                        default: next_s.reset_vector = s.mode_sync[1] ?
                            wdcm_pkg::VEC_SPC_PIN : wdcm_pkg::VEC_PIN;
                    endcase
                end
            end
            wdcm_pkg::RS_FETCH:
            begin
                next_s.rst_count = s.rst_count + 2'h1;
                if (s.rst_count == 2'(wdcm_pkg::VEC_FETCH_CYC - 1))
                begin
                    next_s.vector_fetch = 1'b0;
                    next_s.rst_state    = wdcm_pkg::RS_RUN;
                end
            end
            default: next_s.rst_state = wdcm_pkg::RS_RUN;
        endcase
        if (go_int)
        begin
            next_s.rst_state    = wdcm_pkg::RS_DRIVE;
            next_s.rst_count    = 2'h0;
            next_s.sys_reset_n  = 1'b0;
            next_s.reset_pin_oe = 1'b1;
            next_s.setup        = wdcm_pkg::SETUP_RST;
            next_s.rate_written = 1'b0;
            next_s.win_count    = 7'h00;
            next_s.wd_disabled  = s.boot[wdcm_pkg::BOOT_WD_DIS];
            next_s.armed        = 1'b0;
            next_s.wd_count     = '0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s              <= '0;
            s.e_sync       <= 3'h0;
            s.irq_sync     <= 3'h7;
            s.rp_sync      <= 2'h3;
            s.awready      <= 1'b1;
            s.wready       <= 1'b1;
            s.arready      <= 1'b1;
            s.setup        <= wdcm_pkg::SETUP_RST;
            s.boot         <= wdcm_pkg::BOOT_RST;
            s.wd_disabled  <= wdcm_pkg::BOOT_RST[wdcm_pkg::BOOT_WD_DIS];
            s.rst_state    <= wdcm_pkg::RS_WAIT;
            s.cause        <= wdcm_pkg::CAUSE_PIN;
            s.reset_vector <= wdcm_pkg::VEC_PIN;
        end
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    assign awready       = s.awready;
    assign wready        = s.wready;
    assign bresp         = s.bresp;
    assign bvalid        = s.bvalid;
    assign arready       = s.arready;
    assign rdata         = s.rdata;
    assign rresp         = s.rresp;
    assign rvalid        = s.rvalid;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = s.reset_pin_oe;
    assign irq_request   = s.irq_request;
    assign sys_reset_n   = s.sys_reset_n;
    assign vector_fetch  = s.vector_fetch;
    assign reset_vector  = s.reset_vector;
    assign irq           = s.irq;

    ////////////////////////////////////////////////////////////////////////
    a_disable_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_timeout && s.wd_disabled && s.rp_sync[1] && !cm_fail |=> s.sys_reset_n)
        else $error("disabled watchdog forced a reset");
    a_wd_forces: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_timeout && !s.wd_disabled && !s.reset_inhibit |=> !s.sys_reset_n)
        else $error("watchdog timeout did not force reset");
    a_rate_reset: assert property (@(posedge aclk)
        !aresetn |=> s.setup[1:0] == 2'b00 && !s.setup[wdcm_pkg::SETUP_CME])
        else $error("rate or monitor enable not cleared by reset");
    a_rate_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        s.rate_written && !s.special && s.rst_state == wdcm_pkg::RS_RUN && !go_int
        |=> $stable(s.setup[1:0]))
        else $error("rate changed after its single write");
    a_arm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        do_wr && s.w_en && s.aw_addr == wdcm_pkg::OFF_SERVICE && s.armed
        && s.w_data == wdcm_pkg::SERVICE_CLEAR |=> s.wd_count == '0)
        else $error("armed clear did not zero the watchdog");
    a_clear_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        do_wr && s.w_en && s.aw_addr == wdcm_pkg::OFF_SERVICE && !s.armed
        && !e_edge && !go_int |=> s.wd_count == $past(s.wd_count))
        else $error("unarmed service write disturbed the watchdog");
    a_wd_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        !e_edge && !do_wr && !go_int |=> $stable(s.wd_count))
        else $error("watchdog advanced without a bus clock edge");
    a_cm_fires: assert property (@(posedge aclk) disable iff (!aresetn)
        s.rst_state == wdcm_pkg::RS_RUN && s.rp_sync[1]
        && s.cm_count == CM_W'(CM_CYC - 1) && !e_edge && s.setup[wdcm_pkg::SETUP_CME]
        |=> !s.sys_reset_n && s.cause == wdcm_pkg::CAUSE_CM)
        else $error("clock monitor timeout did not reset");
    a_pin_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.reset_pin_oe) |-> s.reset_pin_oe [*4] ##1 !s.reset_pin_oe
        ##3 !s.sys_reset_n ##1 s.sys_reset_n)
        else $error("reset pin drive or sample timing wrong");
    a_fetch_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.vector_fetch) |-> s.vector_fetch [*3] ##1 !s.vector_fetch)
        else $error("vector fetch window not three cycles");
    a_vector_wd: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.vector_fetch) && s.cause == wdcm_pkg::CAUSE_WD
        |-> s.reset_vector == (s.special ? wdcm_pkg::VEC_SPC_WD : wdcm_pkg::VEC_WD))
        else $error("watchdog reset vector wrong");
endmodule // wdcm_top

// >>> src/wdcm_pkg.sv
package wdcm_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_SERVICE = 8'h00;
    localparam logic [7:0] OFF_SETUP   = 8'h04;
    localparam logic [7:0] OFF_BOOT    = 8'h08;
    localparam logic [7:0] OFF_TEST    = 8'h0c;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_MASK    = 8'h14;
    localparam logic [7:0] OFF_CAUSE   = 8'h18;
    localparam logic [7:0] OFF_VECTOR  = 8'h1c;
    // service codes
    localparam logic [7:0] SERVICE_ARM   = 8'h55;
    localparam logic [7:0] SERVICE_CLEAR = 8'haa;
    // field layouts and reset values
    localparam logic [7:0] SETUP_RST   = 8'h10;
    localparam logic [7:0] SETUP_WMASK = 8'hf8;
    localparam int         SETUP_CME   = 3;
    localparam int         SETUP_EDGE  = 5;
    localparam logic [7:0] BOOT_RST    = 8'h00;
    localparam int         BOOT_WD_DIS = 2;
    localparam int         TEST_INHIB  = 0;
    localparam int         ST_WD       = 0;
    localparam int         ST_CM       = 1;
    // reset vectors
    localparam logic [15:0] VEC_PIN     = 16'hfffe;
    localparam logic [15:0] VEC_CM      = 16'hfffc;
    localparam logic [15:0] VEC_WD      = 16'hfffa;
    localparam logic [15:0] VEC_SPC_PIN = 16'hbffe;
    localparam logic [15:0] VEC_SPC_CM  = 16'hbffc;
    localparam logic [15:0] VEC_SPC_WD  = 16'hbffa;
    // timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int CM_TIMEOUT_NS   = 50000;
    localparam int WD_DIV_LOG2     = 15;
    localparam int RATE_WINDOW_CYC = 64;
    localparam int RST_DRIVE_CYC   = 4;
    localparam int RST_SAMPLE_CYC  = 2;
    localparam int VEC_FETCH_CYC   = 3;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        RS_RUN   = 2'b00,
        RS_DRIVE = 2'b01,
        RS_WAIT  = 2'b10,
        RS_FETCH = 2'b11
    } wdcm_rst_type;
    typedef enum logic [1:0] {
        CAUSE_PIN = 2'b00,
        CAUSE_CM  = 2'b01,
        CAUSE_WD  = 2'b10
    } wdcm_cause_type;
endpackage

// >>> bench/wdcm_top_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module wdcm_top_tb;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        bready = 1, rready = 1, bus_clk_pin = 0, stop_pin = 0;
    logic        special_mode_pin = 0, irq_pin_n = 1, ext_rst_n = 1, irq_ack = 0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'h1;
    logic [1:0]  bresp, rresp, last_resp;
    logic [15:0] reset_vector;
    logic        awready, wready, bvalid, arready, rvalid, reset_pin_out, reset_pin_oe;
    logic        irq_request, sys_reset_n, vector_fetch, irq, prev_rst = 0;
    wire logic   reset_pin_in = reset_pin_oe ? reset_pin_out : ext_rst_n;
    int          failures = 0, checks_done = 0, rcnt = 0, oe_n = 0, vf_n = 0;
    int          cyc = 0, t0 = 0, tfall = 0, r;
    logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
    logic [15:0] rv [9] = '{16'h0, 16'h10, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hfffe, 16'h0};

    wdcm_top #(.WD_DIV_LOG2(4), .CM_CYC(20)) wdcm_top_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .bus_clk_pin(bus_clk_pin), .stop_pin(stop_pin), .special_mode_pin(special_mode_pin),
        .irq_pin_n(irq_pin_n), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .irq_ack(irq_ack), .irq_request(irq_request),
        .sys_reset_n(sys_reset_n), .vector_fetch(vector_fetch),
        .reset_vector(reset_vector), .irq(irq));

    always #4 aclk = ~aclk;
    always #28 bus_clk_pin = ~bus_clk_pin;

    ////////////////////////////////////////////////////////////////////////////////
    // pulse length monitor
    always @(posedge aclk)
    begin
        cyc++;
        if (reset_pin_oe === 1'b1) oe_n++;
        else if (oe_n != 0) begin `CHK("pin drive", 4, oe_n) oe_n = 0; end
        if (vector_fetch === 1'b1) vf_n++;
        else if (vf_n != 0) begin `CHK("fetch len", 3, vf_n) vf_n = 0; end
        if (prev_rst === 1'b1 && sys_reset_n === 1'b0) rcnt++;
        prev_rst = sys_reset_n;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        last_resp = bresp;
        if (n >= 100) failures++;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        last_resp = rresp;
        if (n >= 100) failures++;
    endtask

    task automatic wait_rst();
        int n;
        for (n = 0; sys_reset_n !== 1'b0 && n < 3000; n++) @(posedge aclk);
        tfall = cyc;
        for (; sys_reset_n !== 1'b1 && n < 3000; n++) @(posedge aclk);
        if (n >= 3000) failures++;
        repeat (5) @(posedge aclk);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        failures++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wait_rst();
        for (int i = 0; i < 9; i++)
        begin
            rd(ra[i]);
            `CHK("resp", (i == 8) ? wdcm_pkg::RESP_SLVERR : wdcm_pkg::RESP_OKAY, last_resp)
            if (i < 8) `CHK("reset value", rv[i], d[15:0])
        end
        wr(8'h20, 8'hff);
        `CHK("unmapped write", wdcm_pkg::RESP_SLVERR, last_resp)
        wr(8'h04, 8'h11);
        wr(8'h04, 8'h12);
        rd(8'h04);
        `CHK("rate once", 32'h11, d)
        irq_pin_n <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK("irq level", 1'b1, irq_request)
        irq_pin_n <= 1'b1;
        wr(8'h04, 8'h31);
        irq_ack <= 1'b1;
        @(posedge aclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("irq ack", 1'b0, irq_request)
        irq_pin_n <= 1'b0;
        repeat (2) @(posedge aclk);
        irq_pin_n <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK("irq edge", 1'b1, irq_request)
        r = rcnt;
        repeat (6)
        begin
            wr(8'h00, wdcm_pkg::SERVICE_ARM);
            rd(8'h18);
            wr(8'h00, wdcm_pkg::SERVICE_CLEAR);
            t0 = cyc;
            repeat (30) @(posedge aclk);
        end
        `CHK("serviced", r, rcnt)
        repeat (8) wr(8'h00, wdcm_pkg::SERVICE_CLEAR);
        wait_rst();
        `CHK("wd period", 1'b1, (tfall - t0 > 430) && (tfall - t0 < 470))
        rd(8'h18);
        `CHK("cause wd", 32'h2, d)
        rd(8'h1c);
        `CHK("vector wd", 32'hfffa, d)
        rd(8'h04);
        `CHK("setup after", 32'h10, d)
        wr(8'h14, 8'h00);
        wr(8'h04, 8'h08);
        stop_pin <= 1'b1;
        wait_rst();
        stop_pin <= 1'b0;
        rd(8'h18);
        `CHK("cause cm", 32'h1, d)
        rd(8'h1c);
        `CHK("vector cm", 32'hfffc, d)
        `CHK("irq masked", 1'b0, irq)
        wr(8'h14, 8'h02);
        repeat (2) @(posedge aclk);
        `CHK("irq set", 1'b1, irq)
        wr(8'h10, 8'h02);
        repeat (2) @(posedge aclk);
        `CHK("irq clear", 1'b0, irq)
        wr(8'h08, 8'h04);
        ext_rst_n <= 1'b0;
        fork
            wait_rst();
            begin
                repeat (12) @(posedge aclk);
                ext_rst_n <= 1'b1;
            end
        join
        rd(8'h1c);
        `CHK("vector pin", 32'hfffe, d)
        `CHK("vector port", 16'hfffe, reset_vector)
        r = rcnt;
        wr(8'h10, 8'h03);
        wr(8'h04, 8'h00);
        stop_pin <= 1'b1;
        repeat (60) @(posedge aclk);
        stop_pin <= 1'b0;
        wr(8'h04, 8'h08);
        repeat (600) @(posedge aclk);
        `CHK("disabled", r, rcnt)
        rd(8'h10);
        `CHK("wd status", 1'b1, d[0])
        summarize();
    end
endmodule // wdcm_top_tb
